// File: shared/early_filter_cfg.svh
// Register offsets, field positions and reset values of the early threshold and group filter block.
`ifndef EARLY_FILTER_CFG_SVH
`define EARLY_FILTER_CFG_SVH

// Register indices; the byte address on the bus is four times the index.
`define GROUP_HASH_TABLE_LOW_INDEX     8'h00
`define GROUP_HASH_TABLE_SECOND_INDEX  8'h02
`define GROUP_HASH_TABLE_THIRD_INDEX   8'h04
`define GROUP_HASH_TABLE_FOURTH_INDEX  8'h06
`define EARLY_TRANSMIT_CONTROL_INDEX   8'h08
`define EARLY_RECEIVE_CONTROL_INDEX    8'h0A
`define RECEIVE_CONTROL_REGISTER_INDEX 8'h0C
`define EVENT_STATUS_INDEX             8'h0E
`define EVENT_MASK_INDEX               8'h10
`define BLOCK_STATE_INDEX              8'h12

`define EARLY_ENABLE_BIT               7
`define EARLY_THRESHOLD_MSB            4
`define EARLY_UNIT_SHIFT               6

`define EARLY_TRANSMIT_THRESHOLD_RESET 5'h00
`define EARLY_RECEIVE_THRESHOLD_RESET  5'h1F
`define HASH_TABLE_RESET               16'h0000

`define ACCEPT_ALL_FRAMES_BIT          0
`define ACCEPT_ALL_GROUP_FRAMES_BIT    1

`define EVENT_EARLY_RECV_BIT           0
`define EVENT_SEND_START_BIT           1
`define EVENT_GROUP_DROP_BIT           2
`define EVENT_COUNT                    3

`define GROUP_BIT_POSITION             40
`define CRC_POLYNOMIAL                 32'h04C11DB7
`define CRC_SEED                       32'hFFFFFFFF

`endif

// File: shared/early_filter_pkg.sv
// Types shared by the early threshold and group filter block.
package early_filter_pkg;

  typedef logic [4:0]  threshold_type;
  typedef logic [5:0]  hash_index_type;
  typedef logic [15:0] table_word_type;
  typedef logic [2:0]  event_type;

  typedef struct packed {
    logic                     pready;
    logic                     pslverr;
    logic [31:0]              prdata;
    logic                     early_send_enable;
    threshold_type            early_send_threshold;
    logic                     early_recv_enable;
    threshold_type            early_recv_threshold;
    table_word_type [3:0]     hash_table;
    logic                     accept_all_frames;
    logic                     accept_all_group_frames;
    event_type                event_status;
    event_type                event_mask;
    logic                     irq;
    logic                     tx_start;
    logic                     early_recv_pulse;
    logic                     rx_verdict_valid;
    logic                     rx_accept;
    hash_index_type           last_hash;
  } filter_state_type;

endpackage

// File: rtl/group_hash_index.sv
// Six-bit group address hash taken from the CRC of a destination address.
`timescale 1ns/100ps
`default_nettype none
`include "early_filter_cfg.svh"

module group_hash_index
(
  input  wire logic [47:0]                 dest_addr,
  output var early_filter_pkg::hash_index_type hash
);

  // Bytes go in first byte first, each byte least significant bit first, as on the wire.
  always_comb
  begin
    logic [31:0] crc;
    logic        feedback;
    crc      = `CRC_SEED;
    feedback = 1'b0;
    for (int k = 0; k < 6; k++)
    begin
      for (int j = 0; j < 8; j++)
      begin
        feedback = crc[31] ^ dest_addr[47 - 8 * k - 7 + j];
        crc      = {crc[30:0], 1'b0} ^ (feedback ? `CRC_POLYNOMIAL : 32'h00000000);
      end
    end
    hash = crc[31:26];
  end

endmodule
`default_nettype wire

// File: rtl/threshold_watch.sv
// Fires once per packet when the stored byte count passes a 64-byte-unit threshold.
`timescale 1ns/100ps
`default_nettype none
`include "early_filter_cfg.svh"

module threshold_watch
#(
  parameter int COUNT_WIDTH = 11
)
(
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             enable,
  input  wire early_filter_pkg::threshold_type  threshold,
  input  wire logic                             frame_active,
  input  wire logic [COUNT_WIDTH-1:0]           byte_count,
  output logic                                  hit,
  output logic                                  fired
);

  typedef struct packed {
    logic fired;
  } watch_state_type;

  watch_state_type state;
  watch_state_type next_state;
  logic [COUNT_WIDTH-1:0] limit;

  always_comb
  begin
    limit      = COUNT_WIDTH'({threshold, 6'h00});
    hit        = enable && frame_active && !state.fired && (byte_count > limit);
    next_state = state;
    if (!frame_active)
    begin
      next_state.fired = 1'b0;
    end
    else if (hit)
    begin
      next_state.fired = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign fired = state.fired;

endmodule
`default_nettype wire

// File: rtl/early_threshold_multicast_filter.sv
// Early send and receive thresholds and the group address hash filter, with an APB register file.
//
// Behaviour
// - Early send enable selects early or normal start.
// - Send threshold counts 64-byte units, resets zero.
// - Start sending once written bytes exceed threshold.
// - Early receive enable selects early indication.
// - Receive threshold counts 64-byte units, resets 0x1F.
// - Stored bytes past threshold set status, interrupt.
// - Hash index is top six CRC bits.
// - Upper two bits pick word, rest bit.
// - Set table bit accepts the group frame.
// - Clear table bit drops it; table resets zero.
// - Accept-all bits pass every group frame.
`timescale 1ns/100ps
`default_nettype none
`include "early_filter_cfg.svh"

module early_threshold_multicast_filter
#(
  parameter int COUNT_WIDTH = 11
)
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  output logic                        irq,
  input  wire logic                   tx_frame_loading,
  input  wire logic [COUNT_WIDTH-1:0] tx_bytes_written,
  input  wire logic                   tx_frame_queued,
  output logic                        tx_start,
  input  wire logic                   rx_frame_active,
  input  wire logic [COUNT_WIDTH-1:0] rx_bytes_stored,
  output logic                        early_recv_pulse,
  input  wire logic                   rx_da_valid,
  input  wire logic [47:0]            rx_da,
  output logic                        rx_verdict_valid,
  output logic                        rx_accept
);

  early_filter_pkg::filter_state_type state;
  early_filter_pkg::filter_state_type next_state;

  early_filter_pkg::hash_index_type hash;
  logic                             send_hit;
  logic                             send_fired;
  logic                             recv_hit;
  logic                             recv_fired;

  logic                             setup;
  logic                             commit;
  logic [9:0]                       index;
  logic                             mapped;
  logic [31:0]                      read_value;
  logic                             table_bit;
  logic                             is_group;
  logic                             send_now;
  early_filter_pkg::event_type      raised;
  early_filter_pkg::event_type      cleared;

  group_hash_index hasher
  (
    .dest_addr (rx_da),
    .hash      (hash)
  );

  threshold_watch #(.COUNT_WIDTH(COUNT_WIDTH)) send_watch
  (
    .pclk         (pclk),
    .presetn      (presetn),
    .enable       (state.early_send_enable),
    .threshold    (state.early_send_threshold),
    .frame_active (tx_frame_loading),
    .byte_count   (tx_bytes_written),
    .hit          (send_hit),
    .fired        (send_fired)
  );

  threshold_watch #(.COUNT_WIDTH(COUNT_WIDTH)) recv_watch
  (
    .pclk         (pclk),
    .presetn      (presetn),
    .enable       (state.early_recv_enable),
    .threshold    (state.early_recv_threshold),
    .frame_active (rx_frame_active),
    .byte_count   (rx_bytes_stored),
    .hit          (recv_hit),
    .fired        (recv_fired)
  );

  always_comb
  begin
    setup  = psel && !penable;
    commit = psel && penable && state.pready;
    index  = paddr[11:2];
    mapped = 1'b1;
    read_value = 32'h00000000;
    unique case (index)
      10'(`GROUP_HASH_TABLE_LOW_INDEX):     read_value[15:0] = state.hash_table[0];
      10'(`GROUP_HASH_TABLE_SECOND_INDEX):  read_value[15:0] = state.hash_table[1];
      10'(`GROUP_HASH_TABLE_THIRD_INDEX):   read_value[15:0] = state.hash_table[2];
      10'(`GROUP_HASH_TABLE_FOURTH_INDEX):  read_value[15:0] = state.hash_table[3];
      10'(`EARLY_TRANSMIT_CONTROL_INDEX):
      begin
        read_value[`EARLY_ENABLE_BIT]           = state.early_send_enable;
        read_value[`EARLY_THRESHOLD_MSB:0]      = state.early_send_threshold;
      end
      10'(`EARLY_RECEIVE_CONTROL_INDEX):
      begin
        read_value[`EARLY_ENABLE_BIT]           = state.early_recv_enable;
        read_value[`EARLY_THRESHOLD_MSB:0]      = state.early_recv_threshold;
      end
      10'(`RECEIVE_CONTROL_REGISTER_INDEX):
      begin
        read_value[`ACCEPT_ALL_FRAMES_BIT]       = state.accept_all_frames;
        read_value[`ACCEPT_ALL_GROUP_FRAMES_BIT] = state.accept_all_group_frames;
      end
      10'(`EVENT_STATUS_INDEX):             read_value[`EVENT_COUNT-1:0] = state.event_status;
      10'(`EVENT_MASK_INDEX):               read_value[`EVENT_COUNT-1:0] = state.event_mask;
      10'(`BLOCK_STATE_INDEX):
      begin
        read_value[0]    = send_fired;
        read_value[1]    = recv_fired;
        read_value[13:8] = state.last_hash;
      end
      default:                              mapped = 1'b0;
    endcase

    // Upper hash bits choose the word, lower four the bit within it.
    table_bit = state.hash_table[hash[5:4]][hash[3:0]];
    is_group  = rx_da[`GROUP_BIT_POSITION];

    // With early send off the packet starts only once fully queued; with it on, a packet that
    // never crossed the threshold still starts when queued.
    send_now = send_hit || (tx_frame_queued && !(state.early_send_enable && send_fired));

    raised                          = '0;
    raised[`EVENT_EARLY_RECV_BIT]   = recv_hit;
    raised[`EVENT_SEND_START_BIT]   = send_hit;
    raised[`EVENT_GROUP_DROP_BIT]   = rx_da_valid && is_group && !table_bit
                                      && !state.accept_all_frames && !state.accept_all_group_frames;

    cleared = '0;
    if (commit && pwrite && (index == 10'(`EVENT_STATUS_INDEX)))
    begin
      cleared = pwdata[`EVENT_COUNT-1:0];
    end

    next_state = state;

    next_state.pready  = setup;
    next_state.pslverr = setup && !mapped;
    next_state.prdata  = (setup && !pwrite) ? read_value : 32'h00000000;

    if (commit && pwrite && mapped)
    begin
      unique case (index)
        10'(`GROUP_HASH_TABLE_LOW_INDEX):     next_state.hash_table[0] = pwdata[15:0];
        10'(`GROUP_HASH_TABLE_SECOND_INDEX):  next_state.hash_table[1] = pwdata[15:0];
        10'(`GROUP_HASH_TABLE_THIRD_INDEX):   next_state.hash_table[2] = pwdata[15:0];
        10'(`GROUP_HASH_TABLE_FOURTH_INDEX):  next_state.hash_table[3] = pwdata[15:0];
        10'(`EARLY_TRANSMIT_CONTROL_INDEX):
        begin
          next_state.early_send_enable    = pwdata[`EARLY_ENABLE_BIT];
          next_state.early_send_threshold = pwdata[`EARLY_THRESHOLD_MSB:0];
        end
        10'(`EARLY_RECEIVE_CONTROL_INDEX):
        begin
          next_state.early_recv_enable    = pwdata[`EARLY_ENABLE_BIT];
          next_state.early_recv_threshold = pwdata[`EARLY_THRESHOLD_MSB:0];
        end
        10'(`RECEIVE_CONTROL_REGISTER_INDEX):
        begin
          next_state.accept_all_frames       = pwdata[`ACCEPT_ALL_FRAMES_BIT];
          next_state.accept_all_group_frames = pwdata[`ACCEPT_ALL_GROUP_FRAMES_BIT];
        end
        10'(`EVENT_MASK_INDEX):               next_state.event_mask = pwdata[`EVENT_COUNT-1:0];
        default:
        begin
        end
      endcase
    end

    // A new event in the clearing cycle stays set.
    next_state.event_status = (state.event_status & ~cleared) | raised;
    next_state.irq          = |(next_state.event_status & next_state.event_mask);

    next_state.tx_start         = send_now;
    next_state.early_recv_pulse = recv_hit;

    next_state.rx_verdict_valid = rx_da_valid;
    next_state.rx_accept        = 1'b0;
    if (rx_da_valid)
    begin
      next_state.last_hash = hash;
      if (!is_group || state.accept_all_frames || state.accept_all_group_frames)
      begin
        next_state.rx_accept = 1'b1;
      end
      else
      begin
        next_state.rx_accept = table_bit;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state                      <= '0;
      state.early_send_threshold <= `EARLY_TRANSMIT_THRESHOLD_RESET;
      state.early_recv_threshold <= `EARLY_RECEIVE_THRESHOLD_RESET;
      state.hash_table           <= {4{`HASH_TABLE_RESET}};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign pready           = state.pready;
  assign prdata           = state.prdata;
  assign pslverr          = state.pslverr;
  assign irq              = state.irq;
  assign tx_start         = state.tx_start;
  assign early_recv_pulse = state.early_recv_pulse;
  assign rx_verdict_valid = state.rx_verdict_valid;
  assign rx_accept        = state.rx_accept;

endmodule
`default_nettype wire

// File: verif/early_filter_asserts.sv
// Concurrent checks on the ports of the early threshold and group filter block.
`timescale 1ns/100ps
`default_nettype none
module early_filter_asserts
#(
  parameter int COUNT_WIDTH = 11
)
(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pready,
  input wire logic [31:0]            prdata,
  input wire logic                   pslverr,
  input wire logic                   tx_frame_loading,
  input wire logic                   tx_start,
  input wire logic                   rx_frame_active,
  input wire logic [COUNT_WIDTH-1:0] rx_bytes_stored,
  input wire logic                   early_recv_pulse,
  input wire logic                   rx_da_valid,
  input wire logic [47:0]            rx_da,
  input wire logic                   rx_verdict_valid,
  input wire logic                   rx_accept
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && pready; endsequence
  property p_ready_next; s_setup |=> s_access; endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready in access phase");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_err_data; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err_data: assert property (p_err_data) else $error("error reply malformed");
  property p_idle_data; !pready |-> prdata == 32'h0; endproperty
  a_idle_data: assert property (p_idle_data) else $error("read data outside reply");
  property p_verdict; rx_verdict_valid == $past(rx_da_valid); endproperty
  a_verdict: assert property (p_verdict) else $error("verdict timing wrong");
  property p_unicast; rx_da_valid && !rx_da[40] |=> rx_accept; endproperty
  a_unicast: assert property (p_unicast) else $error("single address dropped");
  property p_tx_once; tx_start |=> !tx_start; endproperty
  a_tx_once: assert property (p_tx_once) else $error("send start too long");
  property p_tx_cause; tx_start |-> $past(tx_frame_loading); endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("send start without packet");
  property p_rx_cause; early_recv_pulse |-> $past(rx_frame_active) && $past(rx_bytes_stored) != '0; endproperty
  a_rx_cause: assert property (p_rx_cause) else $error("early receive without packet");
endmodule
bind early_threshold_multicast_filter early_filter_asserts #(.COUNT_WIDTH(COUNT_WIDTH)) u_asserts
(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .prdata(prdata),
 .pslverr(pslverr), .tx_frame_loading(tx_frame_loading), .tx_start(tx_start), .rx_frame_active(rx_frame_active),
 .rx_bytes_stored(rx_bytes_stored), .early_recv_pulse(early_recv_pulse), .rx_da_valid(rx_da_valid),
 .rx_da(rx_da), .rx_verdict_valid(rx_verdict_valid), .rx_accept(rx_accept));
`default_nettype wire

// File: verif/net_path_model.sv
// Network side stand-in: counts bytes of one send or receive packet into memory.
`timescale 1ns/100ps
`default_nettype none
module net_path_model
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go_tx,
  input  wire logic        go_rx,
  input  wire logic [10:0] frame_len,
  output logic             tx_frame_loading,
  output logic [10:0]      tx_bytes_written,
  output logic             tx_frame_queued,
  output logic             rx_frame_active,
  output logic [10:0]      rx_bytes_stored
);
  // Loading stays high through the queued pulse so an early start is not re-armed early.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {tx_frame_loading, tx_bytes_written, tx_frame_queued} <= '0;
      {rx_frame_active, rx_bytes_stored} <= '0;
    end
    else
    begin
      if (go_tx)
        {tx_frame_loading, tx_bytes_written, tx_frame_queued} <= {1'b1, 11'd1, 1'b0};
      else if (tx_frame_queued)
        {tx_frame_loading, tx_bytes_written, tx_frame_queued} <= '0;
      else if (tx_frame_loading)
        {tx_bytes_written, tx_frame_queued} <= {tx_bytes_written + 11'd1, tx_bytes_written + 11'd1 == frame_len};
      if (go_rx)
        {rx_frame_active, rx_bytes_stored} <= {1'b1, 11'd1};
      else if (rx_bytes_stored == frame_len)
        {rx_frame_active, rx_bytes_stored} <= '0;
      else if (rx_frame_active)
        rx_bytes_stored <= rx_bytes_stored + 11'd1;
    end
  end
endmodule
`default_nettype wire

// File: verif/test_early_threshold_multicast_filter.sv
// Self-checking bench for the early threshold and group filter block.
`timescale 1ns/100ps
`default_nettype none
module test_early_threshold_multicast_filter;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rdata, prdata_w;
  logic        go_tx = 1'b0, go_rx = 1'b0, rx_da_valid = 1'b0, err;
  logic [10:0] frame_len = 11'd2, prev_tx, prev_rx, tx_at, rx_at;
  logic [47:0] rx_da = '0;
  logic        pready, pslverr, irq, tx_start, early_recv_pulse, rx_verdict_valid, rx_accept;
  logic        tx_frame_loading, tx_frame_queued, rx_frame_active;
  logic [10:0] tx_bytes_written, rx_bytes_stored;
  logic [5:0]  h;
  int          n_errors = 0, n_tests = 0, tx_cnt = 0, rx_cnt = 0, c0, i;

  early_threshold_multicast_filter dut
  (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .prdata(prdata_w), .pslverr(pslverr), .irq(irq),
   .tx_frame_loading(tx_frame_loading), .tx_bytes_written(tx_bytes_written), .tx_frame_queued(tx_frame_queued),
   .tx_start(tx_start), .rx_frame_active(rx_frame_active), .rx_bytes_stored(rx_bytes_stored),
   .early_recv_pulse(early_recv_pulse), .rx_da_valid(rx_da_valid), .rx_da(rx_da),
   .rx_verdict_valid(rx_verdict_valid), .rx_accept(rx_accept));

  net_path_model partner
  (.pclk(pclk), .presetn(presetn), .go_tx(go_tx), .go_rx(go_rx), .frame_len(frame_len),
   .tx_frame_loading(tx_frame_loading), .tx_bytes_written(tx_bytes_written), .tx_frame_queued(tx_frame_queued),
   .rx_frame_active(rx_frame_active), .rx_bytes_stored(rx_bytes_stored));

  always #10 pclk = ~pclk;

  always @(posedge pclk)
  begin
    prev_tx <= tx_bytes_written;
    prev_rx <= rx_bytes_stored;
    if (tx_start)
    begin
      tx_at <= prev_tx;
      tx_cnt <= tx_cnt + 1;
    end
    if (early_recv_pulse)
    begin
      rx_at <= prev_rx;
      rx_cnt <= rx_cnt + 1;
    end
  end

  task automatic test_done(input bit timeout);
    if (timeout)
      n_errors++;
    $display("TB: checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 9);
    rdata = prdata_w;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1)
      test_done(1'b1);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask

  task automatic frame(input logic tx, input logic [10:0] len);
    @(posedge pclk);
    {go_tx, go_rx, frame_len} <= {tx, !tx, len};
    @(posedge pclk);
    {go_tx, go_rx} <= 2'b00;
    repeat (len + 11'd4) @(posedge pclk);
  endtask

  task automatic send_da(input logic [47:0] da, input logic exp);
    @(posedge pclk);
    {rx_da_valid, rx_da} <= {1'b1, da};
    @(posedge pclk);
    rx_da_valid <= 1'b0;
    @(negedge pclk);
    chk({31'h0, rx_verdict_valid}, 32'h1);
    chk({31'h0, rx_accept}, {31'h0, exp});
  endtask

  // Reference hash: first byte first, each byte low bit first, no final inversion.
  function automatic logic [5:0] hash_of(input logic [47:0] da);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int b = 0; b < 48; b++)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ da[40 - 8 * (b / 8) + b % 8]) ? 32'h04C11DB7 : 32'h0);
    return c[31:26];
  endfunction

  task automatic fill_table(input logic [15:0] fill);
    for (int w = 0; w < 4; w++)
      apb(1'b1, 12'(w * 8), {16'h0, (w == h[5:4]) ? fill ^ (16'h1 << h[3:0]) : fill});
  endtask

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h020, 32'h0);
    rd(12'h028, 32'h1F);
    for (i = 0; i < 4; i++)
      rd(12'(i * 8), 32'h0);
    apb(1'b1, 12'h020, 32'hFFFFFFFF);
    rd(12'h020, 32'h9F);
    apb(1'b1, 12'h028, 32'hFFFFFFFF);
    rd(12'h028, 32'h9F);
    apb(1'b1, 12'h050, 32'hFFFFFFFF);
    rd(12'h050, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("TB: register test done");
    apb(1'b1, 12'h020, 32'h81);
    c0 = tx_cnt;
    frame(1'b1, 11'd100);
    chk({21'h0, tx_at}, 32'd65);
    chk(tx_cnt - c0, 32'd1);
    frame(1'b1, 11'd64);
    chk({21'h0, tx_at}, 32'd64);
    apb(1'b1, 12'h020, 32'h01);
    frame(1'b1, 11'd100);
    chk({21'h0, tx_at}, 32'd100);
    $display("TB: early send test done");
    rd(12'h038, 32'h2);
    apb(1'b1, 12'h038, 32'h7);
    apb(1'b1, 12'h040, 32'h1);
    apb(1'b1, 12'h028, 32'h82);
    c0 = rx_cnt;
    frame(1'b0, 11'd200);
    chk({21'h0, rx_at}, 32'd129);
    rd(12'h038, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h038, 32'h1);
    rd(12'h038, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h040, 32'h0);
    frame(1'b0, 11'd200);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h028, 32'h02);
    frame(1'b0, 11'd200);
    chk(rx_cnt - c0, 32'd2);
    apb(1'b1, 12'h038, 32'h7);
    $display("TB: early receive test done");
    for (i = 0; i < 4; i++)
    begin
      h = hash_of({40'h01005E0000, 8'(i * 77 + 3)});
      fill_table(16'hFFFF);
      send_da({40'h01005E0000, 8'(i * 77 + 3)}, 1'b0);
      fill_table(16'h0000);
      send_da({40'h01005E0000, 8'(i * 77 + 3)}, 1'b1);
    end
    h = hash_of({40'h01005E0000, 8'd3});
    fill_table(16'hFFFF);
    send_da({40'h01005E0000, 8'd3}, 1'b0);
    rd(12'h038, 32'h4);
    send_da(48'h020000000003, 1'b1);
    for (i = 1; i < 3; i++)
    begin
      apb(1'b1, 12'h030, 32'(i));
      send_da({40'h01005E0000, 8'd3}, 1'b1);
    end
    rd(12'h048, {18'h0, h, 8'h00});
    $display("TB: group filter test done");
    test_done(1'b0);
  end
endmodule
`default_nettype wire
